// ### include/imm_ack_pkg.sv
package imm_ack_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] NODE_OFS     = 12'h004;
	localparam logic [11:0] STATUS_OFS   = 12'h008;
	localparam logic [11:0] HDR_LO_OFS   = 12'h00C;
	localparam logic [11:0] HDR_HI_OFS   = 12'h010;

	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] NODE_RST     = 32'h0000_0000;
	localparam int          CTRL_BAND_LSB = 0;
	localparam int          CTRL_SEL_BIT  = 2;
	localparam int          NODE_IDENTIFIER_LSB   = 0;
	localparam int          NODE_SEQ_LSB  = 8;
	localparam int          NODE_TPR_LSB  = 16;
	localparam int          HDR_HI_W      = 30;

	// ****************************************
	// header codes
	// ****************************************
	localparam logic [1:0] PHY_TYPE_ACK  = 2'h3;
	localparam logic [1:0] SUB_MULTI     = 2'h0;
	localparam logic [1:0] SUB_SINGLE    = 2'h1;
	localparam logic [1:0] SUB_EXT       = 2'h2;
	localparam logic [1:0] TPREQ_ADVICE  = 2'h3;

	typedef enum logic [1:0] {
		european_band,
		us_band_one,
		us_band_full,
		us_band_two
	} bandplan_t;

	typedef struct packed {
		logic [24:0] rsvd_hi;
		logic [6:0]  ext_advice;
		logic        link_quality_flag;
		logic [6:0]  seg_map;
		logic        ack_flag;
		logic        ack_kind;
		logic [7:0]  llc_frame_seq_num;
		logic [5:0]  ack_dest_node_bits;
		logic [1:0]  rsvd_lo;
		logic [1:0]  sub_type;
		logic [1:0]  phy_type;
	} ack_hdr_t;

	typedef struct packed {
		logic        ack_request;
		logic        ack_kind_req;
		logic [1:0]  tx_param_request;
		logic [11:0] node_identifier;
		logic [7:0]  llc_frame_seq_num;
		logic [7:0]  seg_ok;
		logic        checksum_ok;
		logic        link_change;
		logic [6:0]  tx_param_partial_advice;
	} ack_req_t;

	typedef struct packed {
		logic        match;
		logic        ack_kind;
		logic        ack_flag;
		logic [6:0]  seg_map;
		logic [6:0]  tx_param_partial_advice;
		logic        rate_up;
		logic        more_redundancy;
	} ack_info_t;

endpackage

// ### design/immediate_ack_header_codec.sv
// Summary of operation
// R1: sub-type field 00 multi-segment, 01 single, 10 extended, 11 reserved.
// R2: acknowledgement goes out as header-only frame type 3.
// R3: destination field holds six low bits of requester node identifier.
// R4: sequence field copies the acknowledged unit's llc frame sequence number.
// R5: kind bit 0 means whole unit, 1 means selective.
// R6: selective request without capability answers whole unit with kind 0.
// R7: whole-unit flag is 1 only if all segments and checksum good.
// R8: selective flag reports only the first segment after the header.
// R9: selective map holds segment two onward, 1 good, 0 errored.
// R10: kind 0 without advice request sends map zero; receiver ignores it.
// R11: european/us_band_one with request 11 put advice in map bits.
// R12: in advice case flag covers whole unit; requester sent kind 0.
// R13: link quality flag 1 recommends a change of parameters.
// R14: quality flag means rate up if all good, else more redundancy.
// R15: us_band_full/us_band_two carry seven-bit advice after quality flag.
// R16: reserved bits sent zero and ignored on reception.
// R17: receiver matches six node bits and sequence number of pending frame.
// R18: acknowledgement emitted only when request bit is 1.
// R19: acknowledgement destination equals requester source address.
// R20: header word built one cycle after request, with valid strobe.
module immediate_ack_header_codec
	import imm_ack_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        req_valid,
	input  wire ack_req_t    req,
	output logic             hdr_valid,
	output ack_hdr_t         hdr,
	input  wire logic        rx_valid,
	input  wire ack_hdr_t    rx_hdr,
	output logic             info_valid,
	output ack_info_t        info
);

	// ****************************************
	// reset release
	// ****************************************
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [31:0] ctrl_r;
	logic [31:0] node_r;
	logic [15:0] tx_cnt_r;
	logic [15:0] rx_cnt_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic        wr_en;
	logic        setup;
	logic        mapped;
	logic [31:0] rd_nxt;
	bandplan_t   band;
	logic        sel_capable;
	logic [5:0]  own_id;
	logic [7:0]  pend_seq;
	logic [1:0]  pend_tpreq;

	assign setup       = psel && !penable;
	assign wr_en       = psel && penable && pwrite;
	assign pready      = 1'b1;
	assign prdata      = prdata_r;
	assign pslverr     = pslverr_r && psel && penable;
	assign band        = bandplan_t'(ctrl_r[CTRL_BAND_LSB +: 2]);
	assign sel_capable = ctrl_r[CTRL_SEL_BIT];
	assign own_id      = node_r[NODE_IDENTIFIER_LSB +: 6];
	assign pend_seq    = node_r[NODE_SEQ_LSB +: 8];
	assign pend_tpreq  = node_r[NODE_TPR_LSB +: 2];

	always_comb begin
		mapped = 1'b1;
		rd_nxt = 32'h0000_0000;
		unique case (paddr)
			CTRL_OFS:   rd_nxt = {29'h0, ctrl_r[2:0]};
			NODE_OFS:   rd_nxt = {14'h0, node_r[17:0]};
			STATUS_OFS: rd_nxt = {rx_cnt_r, tx_cnt_r};
			HDR_LO_OFS: rd_nxt = hdr[31:0];
			HDR_HI_OFS: rd_nxt = {2'h0, hdr[61:32]};
			default:    mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
			pslverr_r <= !mapped;
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= CTRL_RST;
			node_r <= NODE_RST;
		end else if (wr_en) begin
			if (paddr == CTRL_OFS) begin
				ctrl_r <= {29'h0, pwdata[2:0]};
			end
			if (paddr == NODE_OFS) begin
				node_r <= {14'h0, pwdata[17:0]};
			end
		end
	end

	// ****************************************
	// encoder
	// ****************************************
	logic     advice_case;
	logic     sel_eff;
	logic     whole_ok;
	logic     long_band;
	ack_hdr_t hdr_nxt;

	assign long_band   = (band == us_band_full) || (band == us_band_two);
	assign advice_case = !long_band && (req.tx_param_request == TPREQ_ADVICE); // R11
	assign sel_eff     = req.ack_kind_req && sel_capable && !advice_case; // R6 R12
	assign whole_ok    = (&req.seg_ok) && req.checksum_ok; // R7

	always_comb begin
		hdr_nxt                    = '0; // R16
		hdr_nxt.phy_type           = PHY_TYPE_ACK; // R2
		hdr_nxt.sub_type           = SUB_MULTI; // R1
		hdr_nxt.ack_dest_node_bits = req.node_identifier[5:0]; // R3 R19
		hdr_nxt.llc_frame_seq_num  = req.llc_frame_seq_num; // R4
		hdr_nxt.ack_kind           = sel_eff; // R5
		hdr_nxt.ack_flag           = sel_eff ? req.seg_ok[0] : whole_ok; // R7 R8 R12
		if (advice_case) begin
			hdr_nxt.seg_map = req.tx_param_partial_advice; // R11
		end else if (sel_eff) begin
			hdr_nxt.seg_map = req.seg_ok[7:1]; // R9
		end else begin
			hdr_nxt.seg_map = 7'h00; // R10
		end
		hdr_nxt.link_quality_flag = req.link_change; // R13
		if (long_band) begin
			hdr_nxt.ext_advice = req.tx_param_partial_advice; // R15
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hdr_valid <= 1'b0;
		end else begin
			hdr_valid <= req_valid && req.ack_request; // R18 R20
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hdr <= '0;
		end else if (req_valid && req.ack_request) begin
			hdr <= hdr_nxt; // R20
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_cnt_r <= 16'h0000;
		end else if (req_valid && req.ack_request) begin
			tx_cnt_r <= tx_cnt_r + 16'h0001;
		end
	end

	// ****************************************
	// decoder
	// ****************************************
	logic      rx_match;
	logic      rx_all_good;
	logic      rx_adv_case;
	ack_info_t info_nxt;

	assign rx_match = (rx_hdr.phy_type == PHY_TYPE_ACK) && (rx_hdr.sub_type == SUB_MULTI)
		&& (rx_hdr.ack_dest_node_bits == own_id)
		&& (rx_hdr.llc_frame_seq_num == pend_seq); // R17
	assign rx_adv_case = !long_band && (pend_tpreq == TPREQ_ADVICE);
	assign rx_all_good = rx_hdr.ack_flag && (!rx_hdr.ack_kind || (&rx_hdr.seg_map));

	always_comb begin
		info_nxt          = '0;
		info_nxt.match    = rx_match;
		info_nxt.ack_kind = rx_hdr.ack_kind && !rx_adv_case; // R12
		info_nxt.ack_flag = rx_hdr.ack_flag;
		if (info_nxt.ack_kind) begin
			info_nxt.seg_map = rx_hdr.seg_map; // R9 R10
		end
		if (rx_adv_case) begin
			info_nxt.tx_param_partial_advice = rx_hdr.seg_map; // R11
		end else if (long_band) begin
			info_nxt.tx_param_partial_advice = rx_hdr.ext_advice; // R15 R16
		end
		info_nxt.rate_up         = rx_hdr.link_quality_flag && rx_all_good; // R14
		info_nxt.more_redundancy = rx_hdr.link_quality_flag && !rx_all_good; // R14
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			info_valid <= 1'b0;
			info       <= '0;
		end else begin
			info_valid <= rx_valid;
			if (rx_valid) begin
				info <= info_nxt;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rx_cnt_r <= 16'h0000;
		end else if (rx_valid && rx_match) begin
			rx_cnt_r <= rx_cnt_r + 16'h0001;
		end
	end

endmodule

// ### verif/imm_ack_asserts.sv
module imm_ack_asserts
	import imm_ack_pkg::*;
(
	input wire logic      clk,
	input wire logic      rstn,
	input wire logic      req_valid,
	input wire ack_req_t  req,
	input wire logic      hdr_valid,
	input wire ack_hdr_t  hdr,
	input wire logic      rx_valid,
	input wire logic      info_valid,
	input wire ack_info_t info
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ****************************************
	// header and info checks
	// ****************************************
	ack_req_t q_r;
	// last request taken, compared with the header it launches
	always_ff @(posedge clk) begin
		if (req_valid) begin
			q_r <= req;
		end
	end
	sequence taken_s;
		req_valid && req.ack_request;
	endsequence
	a_hdr_latency: assert property (taken_s |=> hdr_valid) else $error("late hdr");
	a_no_request: assert property (req_valid && !req.ack_request |=> !hdr_valid)
		else $error("unasked hdr");
	a_frame_code: assert property (hdr_valid |-> hdr.phy_type == PHY_TYPE_ACK
		&& hdr.sub_type == SUB_MULTI) else $error("bad type");
	a_rsvd_zero: assert property (hdr_valid |-> hdr.rsvd_lo == 2'h0
		&& hdr.rsvd_hi == 25'h0) else $error("rsvd set");
	a_dest_seq: assert property (hdr_valid |->
		hdr.llc_frame_seq_num == q_r.llc_frame_seq_num
		&& hdr.ack_dest_node_bits == q_r.node_identifier[5:0]) else $error("bad dest");
	a_whole_flag: assert property (hdr_valid && !hdr.ack_kind |->
		hdr.ack_flag == (&q_r.seg_ok && q_r.checksum_ok)) else $error("bad flag");
	a_sel_map: assert property (hdr_valid && hdr.ack_kind |-> q_r.ack_kind_req
		&& {hdr.seg_map, hdr.ack_flag} == q_r.seg_ok) else $error("bad map");
	a_map_zero: assert property (hdr_valid && !hdr.ack_kind
		&& q_r.tx_param_request != TPREQ_ADVICE |-> hdr.seg_map == 7'h00) else $error("map set");
	a_quality: assert property (hdr_valid |->
		hdr.link_quality_flag == q_r.link_change) else $error("bad lq");
	a_info_latency: assert property (rx_valid |=> info_valid) else $error("late info");
	a_info_map: assert property (info_valid && !info.ack_kind |->
		info.seg_map == 7'h00) else $error("info map");
endmodule

bind immediate_ack_header_codec imm_ack_asserts u_chk (.clk(clk), .rstn(rstn),
	.req_valid(req_valid), .req(req), .hdr_valid(hdr_valid), .hdr(hdr),
	.rx_valid(rx_valid), .info_valid(info_valid), .info(info));

// ### verif/peer_ack_model.sv
module peer_ack_model
	import imm_ack_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [5:0] dest,
	input  wire logic [7:0] seq,
	input  wire logic [8:0] kfm,
	input  wire logic       lq,
	input  wire logic [6:0] adv,
	output logic            rx_valid,
	output ack_hdr_t        rx_hdr
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// peer acknowledgement sender
	// ****************************************
	initial rx_valid = 1'b0;
	initial rx_hdr = '0;
	always @(posedge clk) begin
		rx_valid <= go;
		if (go) begin
			rx_hdr <= {25'h0, adv, lq, kfm, seq, dest, 2'h0, SUB_MULTI, PHY_TYPE_ACK};
		end else begin
			// idle bus scrambles so stale data is never trusted
			rx_hdr <= ~rx_hdr;
		end
	end
endmodule

// ### verif/tb_immediate_ack_header_codec.sv
module tb_immediate_ack_header_codec
	import imm_ack_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic        req_valid, hdr_valid, rx_valid, info_valid, go, lq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  dest;
	logic [7:0]  seq;
	logic [8:0]  kfm;
	logic [6:0]  adv;
	ack_req_t    req;
	ack_hdr_t    hdr, rx_hdr;
	ack_info_t   info;
	int          mismatches, checks_done, cyc;
	immediate_ack_header_codec dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req_valid(req_valid), .req(req), .hdr_valid(hdr_valid),
		.hdr(hdr), .rx_valid(rx_valid), .rx_hdr(rx_hdr), .info_valid(info_valid), .info(info));
	peer_ack_model peer_m (.clk(clk), .go(go), .dest(dest), .seq(seq), .kfm(kfm), .lq(lq),
		.adv(adv), .rx_valid(rx_valid), .rx_hdr(rx_hdr));
	// ****************************************
	// tasks
	// ****************************************
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task send(input ack_req_t r, input logic [8:0] k, input logic [6:0] e);
		@(posedge clk);
		req <= r; req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		chk(hdr_valid, r.ack_request);
		if (r.ack_request) chk(hdr, {25'h0, e, r.link_change, k, r.llc_frame_seq_num,
			r.node_identifier[5:0], 2'h0, SUB_MULTI, PHY_TYPE_ACK});
	endtask
	task peer(input logic [5:0] dd, input logic [7:0] s, input logic [8:0] k, input logic [18:0] x);
		@(posedge clk);
		dest <= dd; seq <= s; kfm <= k; lq <= 1'b1; adv <= 7'h33; go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
		chk(info_valid, 1'b1);
		chk(info, x);
	endtask
	// ****************************************
	// clock, timeout and tests
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			mismatches = mismatches + 1;
			wrap_up();
		end
	end
	initial begin
		{rstn, psel, penable, pwrite, req_valid, go, lq} = '0;
		{paddr, pwdata, req, dest, seq, kfm, adv} = '0;
		mismatches = 0; checks_done = 0; cyc = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		apb(0, CTRL_OFS, 0); chk(rd, CTRL_RST);
		apb(0, NODE_OFS, 0); chk(rd, NODE_RST);
		apb(0, 12'h014, 0); chk({err, rd}, 33'h1_0000_0000);
		apb(1, NODE_OFS, 32'h0000_5A2A);
		apb(1, CTRL_OFS, 32'h0000_0004);
		apb(0, NODE_OFS, 0); chk(rd, 32'h0000_5A2A);
		send({4'h8, 12'hFC1, 8'h5A, 8'hFF, 2'h3, 7'h33}, 9'h002, 7'h00);
		send({4'h8, 12'hFC1, 8'h5A, 8'h7F, 2'h2, 7'h33}, 9'h000, 7'h00);
		send({4'hC, 12'h3C5, 8'hA7, 8'hA5, 2'h2, 7'h33}, 9'h14B, 7'h00);
		send({4'h4, 12'hFC1, 8'h5A, 8'hFF, 2'h3, 7'h33}, 9'h000, 7'h00);
		send({4'hF, 12'hFC1, 8'h5A, 8'hFF, 2'h2, 7'h33}, 9'h0CE, 7'h00);
		apb(1, CTRL_OFS, 32'h0000_0000);
		send({4'hC, 12'hFC1, 8'h5A, 8'hA5, 2'h2, 7'h33}, 9'h000, 7'h00);
		apb(1, CTRL_OFS, 32'h0000_0002);
		send({4'hB, 12'hFC1, 8'h5A, 8'hFF, 2'h3, 7'h33}, 9'h002, 7'h33);
		peer(6'h2A, 8'h5A, {7'h7F, 2'h3}, {3'h7, 7'h7F, 7'h33, 2'h2});
		peer(6'h2A, 8'h5B, {7'h55, 2'h0}, {3'h0, 7'h00, 7'h33, 2'h1});
		apb(0, HDR_LO_OFS, 0); chk(rd, 32'hE025_A043);
		apb(0, HDR_HI_OFS, 0); chk(rd, 32'h0000_000C);
		apb(0, STATUS_OFS, 0); chk(rd, 32'h0001_0006);
		apb(1, STATUS_OFS, 32'hFFFF_FFFF);
		apb(0, STATUS_OFS, 0); chk(rd, 32'h0001_0006);
		wrap_up();
	end
endmodule
